//--- rtl/floppy_cfg_map.vh
// Offsets, fields and reset values of the floppy and power configuration registers
`ifndef FLOPPY_CFG_MAP_VH
`define FLOPPY_CFG_MAP_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define IDX_FLOPPY_OUTPUT_CONFIG 8'h05
`define IDX_DRIVE_TYPE_IDS 8'h06
`define IDX_POWER_BOOT_SELECT 8'h07
`define IDX_DECODER_LOW_ADDRESS 8'h08

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_FLOPPY_OUTPUT_CONFIG 8'h00
`define RST_DRIVE_TYPE_IDS 8'hFF
`define RST_POWER_BOOT_SELECT 8'h00
`define RST_DECODER_LOW_ADDRESS 8'h00

// ----------------------------------------
// Writable bit masks, reserved bits clear
// ----------------------------------------
`define MASK_FLOPPY_OUTPUT_CONFIG 8'h7F
`define MASK_DRIVE_TYPE_IDS 8'hFF
`define MASK_POWER_BOOT_SELECT 8'hF3
`define MASK_DECODER_LOW_ADDRESS 8'hF0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FOC_PUSH_PULL 0
`define FOC_TRISTATE 1
`define FOC_NON_BURST 2
`define FOC_DENSEL_LO 3
`define FOC_DENSEL_HI 4
`define FOC_SWAP 5
`define FOC_EXT_FOUR 6
`define PBS_BOOT_HI 1
`define PBS_BOOT_LO 0
`define PBS_APD_LO 4
`define PBS_APD_HI 7
`define DLA_MATCH_HI 7
`define DLA_MATCH_LO 4
`define PSS_DENSITY_CTRL 4

`endif

//--- rtl/drive_select_map.v
// Drive and motor select swap and two or four drive decoding
`timescale 1ns/1ps
`default_nettype none
module drive_select_map (
	// Control
	input wire swap,
	input wire ext_four,
	// Controller side selects
	input wire [1:0] drive_num,
	input wire drive_active,
	input wire [1:0] motor_on,
	// Pin side selects, active high
	output reg [3:0] drive_sel,
	output reg [1:0] motor_sel
);
	reg [1:0] eff_num;
	always @* begin
		eff_num = drive_num;
		if (swap && !drive_num[1]) begin
			eff_num = {1'b0, ~drive_num[0]};
		end
		motor_sel = swap ? {motor_on[0], motor_on[1]} : motor_on;
		drive_sel = 4'h0;
		if (drive_active) begin
			if (ext_four) begin
				// Encoded number on the low pins for an external decoder
				drive_sel = {1'b0, 1'b1, eff_num};
			end else if (!eff_num[1]) begin
				drive_sel[eff_num] = 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

//--- rtl/non_burst_strobe.v
// One-pulse-per-byte strobe shaping for non-burst DMA
`timescale 1ns/1ps
`default_nettype none
module non_burst_strobe (
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// Control
	input wire non_burst,
	input wire fifo_enabled,
	// Requests from the controller core
	input wire dma_req_in,
	input wire int_req_in,
	input wire byte_done,
	// Shaped requests
	output reg dma_req_out,
	output reg int_req_out
);
	reg armed;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			armed <= 1'b1;
			dma_req_out <= 1'b0;
			int_req_out <= 1'b0;
		end else if (non_burst && fifo_enabled) begin
			// One pulse, then hold off until the byte completes
			dma_req_out <= dma_req_in && armed;
			int_req_out <= int_req_in && armed;
			if (byte_done) begin
				armed <= 1'b1;
			end else if (dma_req_in || int_req_in) begin
				armed <= 1'b0;
			end
		end else begin
			armed <= 1'b1;
			dma_req_out <= dma_req_in;
			int_req_out <= int_req_in;
		end
	end
endmodule
`default_nettype wire

//--- rtl/floppy_power_config_regs.v
// Floppy output, drive type, power and decoder configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "floppy_cfg_map.vh"
module floppy_power_config_regs (
	// Clock and reset
	input wire REF_CLK,
	input wire ARST_N,
	input wire HW_RESET,
	// Configuration port
	input wire CONFIG_STATE,
	input wire [7:0] CONFIG_INDEX,
	input wire CONFIG_WR,
	input wire CONFIG_RD,
	input wire [7:0] CONFIG_WDATA,
	output reg [7:0] CONFIG_RDATA,
	output reg CONFIG_RVALID,
	// Density control from the parallel and serial setup register
	input wire DENSITY_FORCE_HIGH,
	// Floppy core signals
	input wire [1:0] CORE_DRIVE_NUM,
	input wire CORE_DRIVE_ACTIVE,
	input wire [1:0] CORE_MOTOR_ON,
	input wire CORE_DENSITY,
	input wire CORE_DMA_REQ,
	input wire CORE_INT_REQ,
	input wire CORE_BYTE_DONE,
	input wire CORE_FIFO_ENABLED,
	// Dedicated floppy pins, output and enable
	output reg [3:0] DRIVE_SEL_OUT,
	output reg [3:0] DRIVE_SEL_OE,
	output reg [1:0] MOTOR_SEL_OUT,
	output reg [1:0] MOTOR_SEL_OE,
	output reg SECOND_DENSITY_PIN_OUT,
	output reg SECOND_DENSITY_PIN_OE,
	output reg PUSH_PULL,
	// Parallel port floppy routing, unaffected by output type and tri-state
	output reg [3:0] PP_DRIVE_SEL,
	output reg [1:0] PP_MOTOR_SEL,
	// Request pins
	output reg FLOPPY_DMA_REQUEST,
	output reg FLOPPY_INTERRUPT_PIN,
	// Configuration to other functions
	output reg [1:0] DENSITY_SELECT,
	output reg [7:0] DRIVE_TYPE_IDS,
	output reg [1:0] BOOT_DRIVE,
	output reg [3:0] AUTO_POWER_DOWN,
	output reg [3:0] DECODE_MATCH_LOW
);

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	reg [7:0] floppy_output_config;
	reg [7:0] drive_type_ids;
	reg [7:0] power_boot_select;
	reg [7:0] decoder_low_address;
	wire wr_ok = CONFIG_STATE && CONFIG_WR;

	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			floppy_output_config <= `RST_FLOPPY_OUTPUT_CONFIG;
			drive_type_ids <= `RST_DRIVE_TYPE_IDS;
			power_boot_select <= `RST_POWER_BOOT_SELECT;
			decoder_low_address <= `RST_DECODER_LOW_ADDRESS;
		end else if (HW_RESET) begin
			floppy_output_config <= `RST_FLOPPY_OUTPUT_CONFIG;
			drive_type_ids <= `RST_DRIVE_TYPE_IDS;
			power_boot_select <= `RST_POWER_BOOT_SELECT;
			decoder_low_address <= `RST_DECODER_LOW_ADDRESS;
		end else if (wr_ok) begin
			case (CONFIG_INDEX)
				`IDX_FLOPPY_OUTPUT_CONFIG: begin
					floppy_output_config <= CONFIG_WDATA & `MASK_FLOPPY_OUTPUT_CONFIG;
				end
				`IDX_DRIVE_TYPE_IDS: begin
					drive_type_ids <= CONFIG_WDATA & `MASK_DRIVE_TYPE_IDS;
				end
				`IDX_POWER_BOOT_SELECT: begin
					power_boot_select <= CONFIG_WDATA & `MASK_POWER_BOOT_SELECT;
				end
				`IDX_DECODER_LOW_ADDRESS: begin
					decoder_low_address <= CONFIG_WDATA & `MASK_DECODER_LOW_ADDRESS;
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	reg [7:0] next_rdata;
	always @* begin
		case (CONFIG_INDEX)
			`IDX_FLOPPY_OUTPUT_CONFIG: next_rdata = floppy_output_config;
			`IDX_DRIVE_TYPE_IDS: next_rdata = drive_type_ids;
			`IDX_POWER_BOOT_SELECT: next_rdata = power_boot_select;
			`IDX_DECODER_LOW_ADDRESS: next_rdata = decoder_low_address;
			default: next_rdata = 8'h00;
		endcase
	end

	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			CONFIG_RDATA <= 8'h00;
			CONFIG_RVALID <= 1'b0;
		end else begin
			CONFIG_RVALID <= CONFIG_STATE && CONFIG_RD;
			CONFIG_RDATA <= (CONFIG_STATE && CONFIG_RD) ? next_rdata : 8'h00;
		end
	end

	// ----------------------------------------
	// Drive select mapping and request shaping
	// ----------------------------------------
	wire [3:0] mapped_sel;
	wire [1:0] mapped_motor;
	wire shaped_dma;
	wire shaped_int;

	drive_select_map u_map (
		.swap(floppy_output_config[`FOC_SWAP]),
		.ext_four(floppy_output_config[`FOC_EXT_FOUR]),
		.drive_num(CORE_DRIVE_NUM),
		.drive_active(CORE_DRIVE_ACTIVE),
		.motor_on(CORE_MOTOR_ON),
		.drive_sel(mapped_sel),
		.motor_sel(mapped_motor)
	);

	non_burst_strobe u_strobe (
		.clk(REF_CLK),
		.arst_n(ARST_N),
		.non_burst(floppy_output_config[`FOC_NON_BURST]),
		.fifo_enabled(CORE_FIFO_ENABLED),
		.dma_req_in(CORE_DMA_REQ),
		.int_req_in(CORE_INT_REQ),
		.byte_done(CORE_BYTE_DONE),
		.dma_req_out(shaped_dma),
		.int_req_out(shaped_int)
	);

	// ----------------------------------------
	// Pin drive, registered one cycle after the register update
	// ----------------------------------------
	wire outputs_active = !floppy_output_config[`FOC_TRISTATE];
	wire push_pull = floppy_output_config[`FOC_PUSH_PULL];
	reg [3:0] next_sel_oe;
	reg [1:0] next_motor_oe;
	reg next_den_out;
	reg next_den_oe;
	integer i;

	always @* begin
		next_sel_oe = 4'h0;
		next_motor_oe = 2'h0;
		next_den_out = 1'b1;
		next_den_oe = 1'b0;
		if (outputs_active) begin
			next_den_out = DENSITY_FORCE_HIGH ? 1'b1 : CORE_DENSITY;
			// Open drain drives only the low level, high comes from the pull-up
			next_den_oe = push_pull || !next_den_out;
			for (i = 0; i < 4; i = i + 1) begin
				next_sel_oe[i] = push_pull || !mapped_sel[i];
			end
			for (i = 0; i < 2; i = i + 1) begin
				next_motor_oe[i] = push_pull || !mapped_motor[i];
			end
		end
	end

	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			DRIVE_SEL_OUT <= 4'h0;
			DRIVE_SEL_OE <= 4'h0;
			MOTOR_SEL_OUT <= 2'h0;
			MOTOR_SEL_OE <= 2'h0;
			SECOND_DENSITY_PIN_OUT <= 1'b1;
			SECOND_DENSITY_PIN_OE <= 1'b0;
			PUSH_PULL <= 1'b0;
			PP_DRIVE_SEL <= 4'h0;
			PP_MOTOR_SEL <= 2'h0;
			FLOPPY_DMA_REQUEST <= 1'b0;
			FLOPPY_INTERRUPT_PIN <= 1'b0;
			DENSITY_SELECT <= 2'h0;
			DRIVE_TYPE_IDS <= `RST_DRIVE_TYPE_IDS;
			BOOT_DRIVE <= 2'h0;
			AUTO_POWER_DOWN <= 4'h0;
			DECODE_MATCH_LOW <= 4'h0;
		end else begin
			DRIVE_SEL_OUT <= mapped_sel;
			DRIVE_SEL_OE <= next_sel_oe;
			MOTOR_SEL_OUT <= mapped_motor;
			MOTOR_SEL_OE <= next_motor_oe;
			SECOND_DENSITY_PIN_OUT <= next_den_out;
			SECOND_DENSITY_PIN_OE <= next_den_oe;
			PUSH_PULL <= push_pull;
			// Parallel port path ignores type and tri-state
			PP_DRIVE_SEL <= mapped_sel;
			PP_MOTOR_SEL <= mapped_motor;
			FLOPPY_DMA_REQUEST <= shaped_dma;
			FLOPPY_INTERRUPT_PIN <= shaped_int;
			DENSITY_SELECT <= floppy_output_config[`FOC_DENSEL_HI:`FOC_DENSEL_LO];
			DRIVE_TYPE_IDS <= drive_type_ids;
			BOOT_DRIVE <= power_boot_select[`PBS_BOOT_HI:`PBS_BOOT_LO];
			AUTO_POWER_DOWN <= power_boot_select[`PBS_APD_HI:`PBS_APD_LO];
			DECODE_MATCH_LOW <= decoder_low_address[`DLA_MATCH_HI:`DLA_MATCH_LO];
		end
	end

endmodule
`default_nettype wire

//--- tb/floppy_cfg_props.sv
// Checker for the floppy and power configuration registers
`timescale 1ns/1ps
`default_nettype none
module floppy_cfg_props (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic ARST_N,
	input wire logic HW_RESET,
	// Configuration port
	input wire logic CONFIG_STATE,
	input wire logic [7:0] CONFIG_INDEX,
	input wire logic CONFIG_WR,
	input wire logic CONFIG_RD,
	input wire logic [7:0] CONFIG_WDATA,
	input wire logic [7:0] CONFIG_RDATA,
	input wire logic CONFIG_RVALID,
	// Pin enables and configuration outputs
	input wire logic [3:0] DRIVE_SEL_OE,
	input wire logic [1:0] MOTOR_SEL_OE,
	input wire logic SECOND_DENSITY_PIN_OE,
	input wire logic [7:0] DRIVE_TYPE_IDS,
	input wire logic [1:0] BOOT_DRIVE,
	input wire logic [3:0] AUTO_POWER_DOWN,
	input wire logic [3:0] DECODE_MATCH_LOW
);
	logic [7:0] last_idx;
	wire wr = CONFIG_STATE && CONFIG_WR && !HW_RESET;
	// Unmapped indices read as zero, so every bit counts as reserved there
	wire [7:0] rsv = last_idx == 8'h05 ? 8'h80 : last_idx == 8'h07 ? 8'h0C :
		last_idx == 8'h08 ? 8'h0F : last_idx == 8'h06 ? 8'h00 : 8'hFF;
	always @(posedge REF_CLK) begin
		last_idx <= CONFIG_INDEX;
	end
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);
	AST_RVALID: assert property (CONFIG_STATE && CONFIG_RD |=> CONFIG_RVALID)
		else $error("read not answered");
	AST_NO_RVALID: assert property (!(CONFIG_STATE && CONFIG_RD) |=> !CONFIG_RVALID)
		else $error("read answered without request");
	AST_RSV_ZERO: assert property (CONFIG_RVALID |-> (CONFIG_RDATA & rsv) == 8'h00)
		else $error("reserved bits read nonzero");
	AST_TRISTATE: assert property (wr && CONFIG_INDEX == 8'h05 && CONFIG_WDATA[1] ##1 !HW_RESET |=>
		DRIVE_SEL_OE == 4'h0 && MOTOR_SEL_OE == 2'h0 && !SECOND_DENSITY_PIN_OE) else $error("pins not released");
	AST_POWER_BOOT: assert property (wr && CONFIG_INDEX == 8'h07 ##1 !HW_RESET |=>
		{AUTO_POWER_DOWN, 2'h0, BOOT_DRIVE} == ($past(CONFIG_WDATA, 2) & 8'hF3)) else $error("power boot stale");
	AST_DRIVE_TYPES: assert property (wr && CONFIG_INDEX == 8'h06 ##1 !HW_RESET |=>
		DRIVE_TYPE_IDS == $past(CONFIG_WDATA, 2)) else $error("drive types stale");
	AST_DECODE: assert property (wr && CONFIG_INDEX == 8'h08 ##1 !HW_RESET |=>
		{DECODE_MATCH_LOW, 4'h0} == ($past(CONFIG_WDATA, 2) & 8'hF0)) else $error("decoder stale");
	AST_HW_RESET: assert property (HW_RESET |=> ##1 AUTO_POWER_DOWN == 4'h0 &&
		BOOT_DRIVE == 2'h0 && DRIVE_TYPE_IDS == 8'hFF) else $error("hardware reset missed");
endmodule
`default_nettype wire

//--- tb/cfg_host.sv
// Host model that drives the configuration index port
`timescale 1ns/1ps
`default_nettype none
module cfg_host (
	// Clock
	input wire logic clk,
	// Configuration port
	output logic state,
	output logic [7:0] idx,
	output logic wr,
	output logic rd,
	output logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	initial begin
		state = 1'b0;
		idx = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 8'h00;
	end
	task automatic put(input logic st, input logic [7:0] i, input logic [7:0] d);
		@(negedge clk);
		state = st;
		idx = i;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
		state = 1'b0;
		// Stale data must not look valid
		wdata = ~d;
	endtask
	task automatic get(input logic [7:0] i, output logic [7:0] d, output logic v);
		@(negedge clk);
		state = 1'b1;
		idx = i;
		rd = 1'b1;
		@(negedge clk);
		// Answer stands for one cycle only, so take it before releasing
		d = rdata;
		v = rvalid;
		rd = 1'b0;
		state = 1'b0;
	endtask
endmodule
`default_nettype wire

//--- tb/floppy_power_config_regs_tb.sv
// Self-checking bench for the floppy and power configuration registers
`timescale 1ns/1ps
`default_nettype none
module floppy_power_config_regs_tb;
	logic clk = 1'b0, arst_n = 1'b0, hw_rst = 1'b0, dforce = 1'b0, dens = 1'b0;
	logic dreq = 1'b0, ireq = 1'b0, bdone = 1'b0, act = 1'b1, fifo = 1'b1;
	logic [1:0] num = 2'h0, mot = 2'h0;
	logic st, wr, rd, rv, d2, d2oe, pp, dma, irq;
	logic [7:0] idx, wd, rdat, dtid;
	logic [3:0] dsel, dsoe, ppd, apd, dml;
	logic [1:0] msel, msoe, ppm, boot, dsl;
	int mismatches = 0, tests_run = 0, cyc = 0;
	int m[4] = '{0, 255, 0, 0};
	int msk[4] = '{8'h7F, 8'hFF, 8'hF3, 8'hF0};
	logic [7:0] cfgs[11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h20, 8'h21, 8'h22, 8'h40, 8'h41, 8'h42, 8'h60};
	always #50 clk = ~clk;
	cfg_host h (.clk(clk), .state(st), .idx(idx), .wr(wr), .rd(rd), .wdata(wd), .rdata(rdat), .rvalid(rv));
	floppy_power_config_regs uut (.REF_CLK(clk), .ARST_N(arst_n), .HW_RESET(hw_rst), .CONFIG_STATE(st),
		.CONFIG_INDEX(idx), .CONFIG_WR(wr), .CONFIG_RD(rd), .CONFIG_WDATA(wd), .CONFIG_RDATA(rdat),
		.CONFIG_RVALID(rv), .DENSITY_FORCE_HIGH(dforce), .CORE_DRIVE_NUM(num), .CORE_DRIVE_ACTIVE(act),
		.CORE_MOTOR_ON(mot), .CORE_DENSITY(dens), .CORE_DMA_REQ(dreq), .CORE_INT_REQ(ireq),
		.CORE_BYTE_DONE(bdone), .CORE_FIFO_ENABLED(fifo), .DRIVE_SEL_OUT(dsel), .DRIVE_SEL_OE(dsoe),
		.MOTOR_SEL_OUT(msel), .MOTOR_SEL_OE(msoe), .SECOND_DENSITY_PIN_OUT(d2), .SECOND_DENSITY_PIN_OE(d2oe),
		.PUSH_PULL(pp), .PP_DRIVE_SEL(ppd), .PP_MOTOR_SEL(ppm), .FLOPPY_DMA_REQUEST(dma),
		.FLOPPY_INTERRUPT_PIN(irq), .DENSITY_SELECT(dsl), .DRIVE_TYPE_IDS(dtid), .BOOT_DRIVE(boot),
		.AUTO_POWER_DOWN(apd), .DECODE_MATCH_LOW(dml));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic rdchk(input int i);
		logic [7:0] d;
		logic v;
		h.get(i[7:0], d, v);
		chk("read valid", 8'h01, {7'h0, v});
		chk("read data", (i >= 5 && i <= 8) ? m[i-5][7:0] : 8'h00, d);
	endtask
	task automatic outs();
		chk("drive types", m[1][7:0], dtid);
		chk("power boot", m[2][7:0], {apd, 2'h0, boot});
		chk("decoder", m[3][7:0], {dml, 4'h0});
		chk("output type", {7'h0, m[0][0]}, {7'h0, pp});
		chk("density select", {6'h0, m[0][4:3]}, {6'h0, dsl});
	endtask
	task automatic pins();
		logic [3:0] es;
		logic [1:0] em;
		logic ed, t, p;
		t = m[0][1];
		p = m[0][0];
		// Swap exchanges drives 0 and 1 only, in either decoding
		es = !act ? 4'h0 : m[0][6] ? {2'b01, num[1], num[0] ^ (m[0][5] & ~num[1])} :
			4'h1 << (num[0] ^ m[0][5]);
		em = m[0][5] ? {mot[0], mot[1]} : mot;
		ed = dforce | dens;
		chk("select", {2'h0, em, es}, {2'h0, msel, dsel});
		chk("select enable", t ? 8'h00 : p ? 8'h3F : {2'h0, ~em, ~es}, {2'h0, msoe, dsoe});
		chk("density", {6'h0, ~t & (p | ~ed), t ? d2 : ed}, {6'h0, d2oe, d2});
		chk("parallel path", {2'h0, em, es}, {2'h0, ppm, ppd});
	endtask
	task automatic count(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(negedge clk);
			c += (dma === 1'b1) + (irq === 1'b1);
		end
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			print_verdict();
		end
	end
	initial begin
		int i, c;
		logic [7:0] d;
		void'($urandom(30));
		repeat (10) @(negedge clk);
		arst_n = 1'b1;
		for (i = 5; i <= 9; i++) rdchk(i);
		for (i = 5; i <= 8; i++) begin
			h.put(1'b1, i[7:0], 8'hFF);
			m[i-5] = msk[i-5];
			rdchk(i);
		end
		repeat (12) begin
			i = 5 + $urandom % 4;
			d = $urandom;
			h.put(1'b1, i[7:0], d);
			m[i-5] = d & msk[i-5];
			rdchk(i);
			outs();
		end
		h.put(1'b0, 8'h06, 8'h12);
		rdchk(6);
		foreach (cfgs[k]) begin
			h.put(1'b1, 8'h05, cfgs[k]);
			m[0] = cfgs[k];
			repeat (4) begin
				@(negedge clk);
				num = 2'($urandom % (cfgs[k][6] ? 4 : 2));
				mot = 2'($urandom);
				act = 1'($urandom);
				dforce = 1'($urandom);
				dens = 1'($urandom);
				repeat (3) @(negedge clk);
				pins();
			end
		end
		h.put(1'b1, 8'h05, 8'h04);
		m[0] = 8'h04;
		dreq = 1'b1;
		ireq = 1'b1;
		count(16, c);
		chk("one strobe each", 8'h02, c[7:0]);
		bdone = 1'b1;
		@(negedge clk);
		bdone = 1'b0;
		count(16, c);
		chk("strobe per byte", 8'h02, c[7:0]);
		h.put(1'b1, 8'h05, 8'h00);
		m[0] = 0;
		repeat (3) @(negedge clk);
		count(8, c);
		chk("burst level", 8'h10, c[7:0]);
		h.put(1'b1, 8'h07, 8'hF1);
		m[2] = 8'hF1;
		@(negedge clk);
		outs();
		arst_n = 1'b0;
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		m = '{0, 255, 0, 0};
		@(negedge clk);
		outs();
		h.put(1'b1, 8'h07, 8'hF1);
		h.put(1'b1, 8'h06, 8'h12);
		hw_rst = 1'b1;
		@(negedge clk);
		hw_rst = 1'b0;
		m = '{0, 255, 0, 0};
		repeat (2) @(negedge clk);
		outs();
		print_verdict();
	end
endmodule
bind floppy_power_config_regs floppy_cfg_props props_i (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
	.HW_RESET(HW_RESET), .CONFIG_STATE(CONFIG_STATE), .CONFIG_INDEX(CONFIG_INDEX), .CONFIG_WR(CONFIG_WR),
	.CONFIG_RD(CONFIG_RD), .CONFIG_WDATA(CONFIG_WDATA), .CONFIG_RDATA(CONFIG_RDATA),
	.CONFIG_RVALID(CONFIG_RVALID), .DRIVE_SEL_OE(DRIVE_SEL_OE), .MOTOR_SEL_OE(MOTOR_SEL_OE),
	.SECOND_DENSITY_PIN_OE(SECOND_DENSITY_PIN_OE), .DRIVE_TYPE_IDS(DRIVE_TYPE_IDS), .BOOT_DRIVE(BOOT_DRIVE),
	.AUTO_POWER_DOWN(AUTO_POWER_DOWN), .DECODE_MATCH_LOW(DECODE_MATCH_LOW));
`default_nettype wire
